// ---- design/raster_writer.sv ----
// span, line and clear writer into the interleaved frame and depth buffers
//
// Notes on behaviour
// - with depth test on, nearer pixels write colour and depth, farther ones are dropped
// - depth keeps all 24 bits from command input to stored depth planes
// - base configuration uses 8 colour, 2 window-id and 2 overlay planes
// - extended configuration uses 24 colour, 4 window-id, 4 overlay, 24 depth planes
// - depth planes are used only when the 24-bit colour option exists
// - 8-bit colour draws colour index only, 8-bit single or 4-bit double
// - 24-bit colour offers RGB or index, single 24-bit or double 12-bit
// - each span or line write touches only the planes of the active drawing mode
// - shaded colours may be dithered by a 4 x 4 positional pattern
// - stored window id masks pixels against the target window
// - stored window id selects colour format and buffering per pixel
// - spans and lines are iterated from slopes into colour and depth planes
// - pixel array is 1280 columns by 1024 rows
// - overlay planes are 2 or 4 per pixel by configuration and never drawn
// - a fast clear fills whole words on four rows at once
// - five-pixel words, lanes written in turn, depth at the same address
module raster_writer #(
	parameter int HAS_EXT = 1
) (
	// clock and reset
	input  logic                         CLK_SYS,
	input  logic                         RESET,
	// register port
	input  logic [rast_pkg::ADDR_W-1:0]  REG_ADDR,
	input  logic [31:0]                  REG_WDATA,
	input  logic                         REG_WR,
	input  logic                         REG_RD,
	output logic [31:0]                  REG_RDATA,
	// commands from the geometry engine
	input  logic                         CMD_VALID,
	output logic                         CMD_READY,
	input  logic [1:0]                   CMD_OP,
	input  logic [10:0]                  CMD_X,
	input  logic [9:0]                   CMD_Y,
	input  logic [23:0]                  CMD_COLOR,
	input  logic [23:0]                  CMD_Z,
	input  logic [15:0]                  CMD_DX,
	input  logic [15:0]                  CMD_DY,
	input  logic [15:0]                  CMD_DR,
	input  logic [15:0]                  CMD_DG,
	input  logic [15:0]                  CMD_DB,
	input  logic [31:0]                  CMD_DZ,
	input  logic [10:0]                  CMD_COUNT,
	// frame and depth buffer memory
	output logic [17:0]                  FB_ADDR,
	output logic [2:0]                   FB_LANE,
	output logic                         FB_RD,
	input  logic [rast_pkg::PIX_W-1:0]   FB_RDATA,
	output logic                         FB_WR,
	output logic [rast_pkg::PIX_W-1:0]   FB_WDATA,
	output logic [rast_pkg::PIX_W-1:0]   FB_WMASK,
	output logic                         FB_QUAD
);
	import rast_pkg::*;

	if (HAS_EXT != 0 && HAS_EXT != 1) begin : g_chk
		$error("HAS_EXT must be 0 or 1");
	end

	////////////////////////////////////////////////////////////////////////
	// decoding helpers

	function automatic logic [7:0] word_of(input logic [10:0] x);
		logic [27:0] p;
		p = 28'(x) * 28'd52429;
		return p[25:18];
	endfunction : word_of

	function automatic logic [2:0] lane_of(input logic [10:0] x);
		logic [10:0] t;
		t = x - 11'(word_of(x)) * 11'd5;
		return t[2:0];
	endfunction : lane_of

	function automatic logic [23:0] sext16(input logic [15:0] v);
		return {{8{v[15]}}, v};
	endfunction : sext16

	////////////////////////////////////////////////////////////////////////
	// state

	state_t      state_reg;
	logic [3:0]  ctrl_reg;
	logic [3:0]  twid_reg;
	logic [31:0] modes_reg;
	logic [23:0] clrcol_reg;
	logic [15:0] drawn_reg;
	logic [15:0] hidden_reg;
	logic [31:0] rdata_reg;
	logic [23:0] x_reg;
	logic [23:0] y_reg;
	logic [15:0] r_reg;
	logic [15:0] g_reg;
	logic [15:0] b_reg;
	logic [31:0] z_reg;
	logic [15:0] dx_reg;
	logic [15:0] dy_reg;
	logic [15:0] dr_reg;
	logic [15:0] dg_reg;
	logic [15:0] db_reg;
	logic [31:0] dz_reg;
	logic [10:0] left_reg;
	logic [7:0]  cword_reg;
	logic [7:0]  cgroup_reg;
	logic [17:0] fb_addr_reg;
	logic [2:0]  fb_lane_reg;
	logic        fb_rd_reg;
	logic        fb_wr_reg;
	logic [55:0] fb_wdata_reg;
	logic [55:0] fb_wmask_reg;
	logic        fb_quad_reg;

	logic [10:0] px;
	logic [9:0]  py;
	logic [23:0] z_new;
	logic [3:0]  wid_old;
	logic [1:0]  mode;
	logic        depth_on;
	logic        visible;
	logic        wid_ok;
	logic        pass;
	logic [7:0]  d8 [3];
	logic [3:0]  d4 [3];
	logic [23:0] col_data;
	logic [23:0] col_mask;
	logic [23:0] ci;

	assign px        = x_reg[FRAC+10:FRAC];
	assign py        = y_reg[FRAC+9:FRAC];
	assign z_new     = z_reg[31:8];
	assign depth_on  = ctrl_reg[CTL_DEPTH] && (HAS_EXT == 1);
	assign CMD_READY = (state_reg == S_IDLE);

	////////////////////////////////////////////////////////////////////////
	// register port

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			ctrl_reg   <= CTRL_RST;
			twid_reg   <= 4'h0;
			modes_reg  <= MODES_RST;
			clrcol_reg <= 24'h0;
		end else if (REG_WR) begin
			case (REG_ADDR)
				OFF_CTRL:   ctrl_reg   <= REG_WDATA[3:0];
				OFF_TWID:   twid_reg   <= REG_WDATA[3:0];
				OFF_MODES:  modes_reg  <= REG_WDATA;
				OFF_CLRCOL: clrcol_reg <= REG_WDATA[23:0];
				default:    ;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			rdata_reg <= 32'h0;
		end else if (REG_RD) begin
			case (REG_ADDR)
				OFF_CTRL:   rdata_reg <= {28'h0, ctrl_reg};
				OFF_TWID:   rdata_reg <= {28'h0, twid_reg};
				OFF_MODES:  rdata_reg <= modes_reg;
				OFF_CLRCOL: rdata_reg <= {8'h0, clrcol_reg};
				OFF_STATUS: rdata_reg <= {30'h0, HAS_EXT[0], state_reg != S_IDLE};
				OFF_DRAWN:  rdata_reg <= {16'h0, drawn_reg};
				OFF_HIDDEN: rdata_reg <= {16'h0, hidden_reg};
				default:    rdata_reg <= 32'h0;
			endcase
		end else begin
			rdata_reg <= 32'h0;
		end
	end

	assign REG_RDATA = rdata_reg;

	////////////////////////////////////////////////////////////////////////
	// pixel verdict and colour packing

	always_comb begin
		wid_old = (HAS_EXT == 1) ? FB_RDATA[WID_LSB +: 4] : {2'b00, FB_RDATA[WID_LSB +: 2]};
		mode    = modes_reg[{wid_old, 1'b0} +: 2];
	end

	depth_gate u_gate (
		.z_new    (z_new),
		.z_old    (FB_RDATA[Z_LSB +: Z_W]),
		.depth_on (depth_on),
		.wid_old  (wid_old),
		.wid_tgt  (twid_reg),
		.mask_on  (ctrl_reg[CTL_WMASK]),
		.visible  (visible),
		.wid_ok   (wid_ok),
		.pass     (pass)
	);

	for (genvar i = 0; i < 3; i++) begin : g_dith
		logic [15:0] comp;
		assign comp = (i == 0) ? r_reg : (i == 1) ? g_reg : b_reg;
		dither_cell u_dith (
			.comp   (comp),
			.px     (px[1:0]),
			.py     (py[1:0]),
			.enable (ctrl_reg[CTL_DITHER]),
			.out8   (d8[i]),
			.out4   (d4[i])
		);
	end

	always_comb begin
		ci       = {b_reg[15:8], g_reg[15:8], r_reg[15:8]};
		col_data = 24'h0;
		col_mask = 24'h0;
		if (HAS_EXT == 0) begin
			if (mode[MD_DBL]) begin
				col_data = ctrl_reg[CTL_BACK] ? {16'h0, ci[3:0], 4'h0} : {20'h0, ci[3:0]};
				col_mask = ctrl_reg[CTL_BACK] ? 24'h0000f0 : 24'h00000f;
			end else begin
				col_data = {16'h0, ci[7:0]};
				col_mask = 24'h0000ff;
			end
		end else begin
			case (mode)
				2'b01:   col_data = {d8[2], d8[1], d8[0]};
				2'b11:   col_data = {2{d4[2], d4[1], d4[0]}};
				2'b10:   col_data = {2{ci[11:0]}};
				default: col_data = ci;
			endcase
			if (mode[MD_DBL]) begin
				col_mask = ctrl_reg[CTL_BACK] ? 24'hfff000 : 24'h000fff;
			end else begin
				col_mask = 24'hffffff;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			state_reg <= S_IDLE;
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (CMD_VALID) begin
						state_reg <= (CMD_OP == OP_CLEAR) ? S_CLEAR : S_FETCH;
					end
				end
				S_FETCH: state_reg <= S_WAIT;
				S_WAIT:  state_reg <= S_TEST;
				S_TEST:  state_reg <= (left_reg == 11'h0) ? S_IDLE : S_FETCH;
				S_CLEAR: begin
					if (cword_reg == WORD_LAST && cgroup_reg == GROUP_LAST) begin
						state_reg <= S_IDLE;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// iterators, loaded from the command and stepped after each pixel
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			{x_reg, y_reg, z_reg, dz_reg} <= '0;
			{r_reg, g_reg, b_reg}         <= '0;
			{dx_reg, dy_reg}              <= '0;
			{dr_reg, dg_reg, db_reg}      <= '0;
			left_reg                      <= 11'h0;
		end else if (state_reg == S_IDLE && CMD_VALID) begin
			x_reg    <= {1'b0, CMD_X, 12'h000};
			y_reg    <= {2'b00, CMD_Y, 12'h000};
			r_reg    <= {CMD_COLOR[7:0], 8'h80};
			g_reg    <= {CMD_COLOR[15:8], 8'h80};
			b_reg    <= {CMD_COLOR[23:16], 8'h80};
			z_reg    <= {CMD_Z, 8'h00};
			dx_reg   <= (CMD_OP == OP_SPAN) ? 16'h1000 : CMD_DX;
			dy_reg   <= (CMD_OP == OP_SPAN) ? 16'h0000 : CMD_DY;
			dr_reg   <= CMD_DR;
			dg_reg   <= CMD_DG;
			db_reg   <= CMD_DB;
			dz_reg   <= CMD_DZ;
			left_reg <= CMD_COUNT;
		end else if (state_reg == S_TEST) begin
			x_reg    <= x_reg + sext16(dx_reg);
			y_reg    <= y_reg + sext16(dy_reg);
			r_reg    <= r_reg + dr_reg;
			g_reg    <= g_reg + dg_reg;
			b_reg    <= b_reg + db_reg;
			z_reg    <= z_reg + dz_reg;
			left_reg <= left_reg - 11'h1;
		end
	end

	// clear walk over word columns and four-row groups
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			cword_reg  <= 8'h0;
			cgroup_reg <= 8'h0;
		end else if (state_reg == S_CLEAR) begin
			cword_reg <= cword_reg + 8'h1;
			if (cword_reg == WORD_LAST) begin
				cgroup_reg <= cgroup_reg + 8'h1;
			end
		end else begin
			cword_reg  <= 8'h0;
			cgroup_reg <= 8'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame buffer port

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			fb_addr_reg  <= 18'h0;
			fb_lane_reg  <= 3'h0;
			fb_rd_reg    <= 1'b0;
			fb_wr_reg    <= 1'b0;
			fb_wdata_reg <= '0;
			fb_wmask_reg <= '0;
			fb_quad_reg  <= 1'b0;
		end else begin
			fb_rd_reg   <= 1'b0;
			fb_wr_reg   <= 1'b0;
			fb_quad_reg <= 1'b0;
			case (state_reg)
				S_FETCH: begin
					fb_addr_reg <= {py, word_of(px)};
					fb_lane_reg <= lane_of(px);
					fb_rd_reg   <= (px < 11'(COLS));
				end
				S_TEST: begin
					fb_wr_reg    <= pass && (px < 11'(COLS));
					fb_wdata_reg <= {z_new, 8'h00, col_data};
					fb_wmask_reg <= {depth_on ? 24'hffffff : 24'h0, 8'h00, col_mask};
				end
				S_CLEAR: begin
					fb_addr_reg  <= {cgroup_reg, 2'b00, cword_reg};
					fb_lane_reg  <= LANE_ALL;
					fb_wr_reg    <= 1'b1;
					fb_quad_reg  <= 1'b1;
					fb_wdata_reg <= {Z_FAR, 8'h00, clrcol_reg};
					fb_wmask_reg <= {depth_on ? 24'hffffff : 24'h0, 8'h00,
						(HAS_EXT == 1) ? 24'hffffff : 24'h0000ff};
				end
				default: ;
			endcase
		end
	end

	assign FB_ADDR  = fb_addr_reg;
	assign FB_LANE  = fb_lane_reg;
	assign FB_RD    = fb_rd_reg;
	assign FB_WR    = fb_wr_reg;
	assign FB_WDATA = fb_wdata_reg;
	assign FB_WMASK = fb_wmask_reg;
	assign FB_QUAD  = fb_quad_reg;

	// drawn and hidden pixel counters
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			drawn_reg  <= 16'h0;
			hidden_reg <= 16'h0;
		end else if (state_reg == S_TEST && px < 11'(COLS)) begin
			if (pass) begin
				drawn_reg <= drawn_reg + 16'h1;
			end else if (!visible) begin
				hidden_reg <= hidden_reg + 16'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);

	sequence rd_to_test;
		FB_RD ##1 !FB_RD && state_reg == S_TEST;
	endsequence

	sequence test_to_write;
		##1 FB_WR && FB_WMASK[55:32] == 24'hffffff;
	endsequence

	pixel_fetch_a: assert property (FB_RD |-> rd_to_test)
		else $error("pixel read not followed by test");
	depth_write_a: assert property (state_reg == S_TEST && depth_on && wid_ok
		&& z_new < FB_RDATA[Z_LSB +: Z_W] && px < 11'(COLS) |-> test_to_write)
		else $error("nearer pixel did not write depth");
	depth_hide_a: assert property (state_reg == S_TEST && depth_on
		&& z_new >= FB_RDATA[Z_LSB +: Z_W] |=> !FB_WR)
		else $error("hidden pixel was written");
	depth_bits_a: assert property (state_reg == S_TEST |=>
		FB_WDATA[55:32] == $past(z_reg[31:8]))
		else $error("depth lost precision");
	depth_option_a: assert property (HAS_EXT == 0 |-> FB_WMASK[55:8] == 48'h0)
		else $error("base configuration touched extra planes");
	plane_keep_a: assert property (FB_WR |-> FB_WMASK[31:24] == 8'h00)
		else $error("window or overlay planes written");
	wid_mask_a: assert property (state_reg == S_TEST && ctrl_reg[CTL_WMASK]
		&& wid_old != twid_reg |=> !FB_WR)
		else $error("masked pixel written");
	clear_quad_a: assert property (state_reg == S_CLEAR |=> FB_QUAD && FB_WR
		&& FB_LANE == LANE_ALL)
		else $error("clear did not fill a quad word");
	addr_range_a: assert property (FB_RD |-> FB_ADDR[17:8] <= 10'(ROWS - 1)
		&& FB_LANE < 3'(WORD_PIX))
		else $error("pixel address out of range");
	ready_idle_a: assert property (CMD_VALID && CMD_READY && CMD_OP != OP_CLEAR
		&& CMD_X < 11'(COLS) |=> !CMD_READY ##1 FB_RD)
		else $error("command did not start a pixel fetch");

endmodule : raster_writer

// ---- design/rast_pkg.sv ----
// shared constants for the raster pixel writer
package rast_pkg;

	// register port
	localparam int          ADDR_W     = 8;
	localparam logic [7:0]  OFF_CTRL   = 8'h00;
	localparam logic [7:0]  OFF_TWID   = 8'h04;
	localparam logic [7:0]  OFF_MODES  = 8'h08;
	localparam logic [7:0]  OFF_CLRCOL = 8'h0c;
	localparam logic [7:0]  OFF_STATUS = 8'h10;
	localparam logic [7:0]  OFF_DRAWN  = 8'h14;
	localparam logic [7:0]  OFF_HIDDEN = 8'h18;

	// control bit positions
	localparam int          CTL_DEPTH  = 0;
	localparam int          CTL_DITHER = 1;
	localparam int          CTL_WMASK  = 2;
	localparam int          CTL_BACK   = 3;
	localparam logic [3:0]  CTRL_RST   = 4'h0;
	localparam logic [31:0] MODES_RST  = 32'h0;

	// mode table entry bits
	localparam int          MD_RGB     = 0;
	localparam int          MD_DBL     = 1;

	// pixel word layout
	localparam int          PIX_W      = 56;
	localparam int          COL_LSB    = 0;
	localparam int          WID_LSB    = 24;
	localparam int          OVL_LSB    = 28;
	localparam int          Z_LSB      = 32;
	localparam int          Z_W        = 24;
	localparam logic [23:0] Z_FAR      = 24'hffffff;

	// screen geometry
	localparam int          COLS       = 1280;
	localparam int          ROWS       = 1024;
	localparam int          WORD_PIX   = 5;
	localparam int          QUAD_ROWS  = 4;
	localparam logic [7:0]  WORD_LAST  = 8'hff;
	localparam logic [7:0]  GROUP_LAST = 8'hff;
	localparam logic [2:0]  LANE_ALL   = 3'h7;
	localparam int          FRAC       = 12;

	// commands
	localparam logic [1:0]  OP_SPAN    = 2'h0;
	localparam logic [1:0]  OP_LINE    = 2'h1;
	localparam logic [1:0]  OP_CLEAR   = 2'h2;

	// 4 x 4 ordered dither thresholds, row-major, four bits each
	localparam logic [63:0] DITHER_TBL = 64'h5d7f_91b3_6e4c_a280;

	typedef enum {S_IDLE, S_FETCH, S_WAIT, S_TEST, S_CLEAR} state_t;

endpackage : rast_pkg

// ---- design/dither_cell.sv ----
// positional dither of one 8.8 colour component
module dither_cell (
	// component and position
	input  logic [15:0] comp,
	input  logic [1:0]  px,
	input  logic [1:0]  py,
	input  logic        enable,
	// dithered results
	output logic [7:0]  out8,
	output logic [3:0]  out4
);
	import rast_pkg::*;

	logic [3:0] thr;
	logic       up8;
	logic       up4;

	always_comb begin
		thr  = DITHER_TBL[{py, px, 2'b00} +: 4];
		up8  = enable && (comp[7:4] > thr);
		up4  = enable && (comp[11:8] > thr);
		out8 = (up8 && comp[15:8] != 8'hff) ? comp[15:8] + 8'h01 : comp[15:8];
		out4 = (up4 && comp[15:12] != 4'hf) ? comp[15:12] + 4'h1 : comp[15:12];
	end

endmodule : dither_cell

// ---- design/depth_gate.sv ----
// depth test and window mask for one pixel
module depth_gate (
	// depth
	input  logic [23:0] z_new,
	input  logic [23:0] z_old,
	input  logic        depth_on,
	// window identifier
	input  logic [3:0]  wid_old,
	input  logic [3:0]  wid_tgt,
	input  logic        mask_on,
	// verdict
	output logic        visible,
	output logic        wid_ok,
	output logic        pass
);
	always_comb begin
		visible = !depth_on || (z_new < z_old);
		wid_ok  = !mask_on || (wid_old == wid_tgt);
		pass    = visible && wid_ok;
	end

endmodule : depth_gate

// ---- sim/geom_src.sv ----
// geometry engine model offering primitives on the command port
module geom_src (
	// clock
	input  wire logic        clk,
	// handshake
	input  wire logic        CMD_READY,
	output logic             CMD_VALID,
	// primitive fields
	output logic [1:0]       CMD_OP,
	output logic [10:0]      CMD_X,
	output logic [9:0]       CMD_Y,
	output logic [23:0]      CMD_COLOR,
	output logic [23:0]      CMD_Z,
	output logic [15:0]      CMD_DX,
	output logic [15:0]      CMD_DY,
	output logic [15:0]      CMD_DR,
	output logic [15:0]      CMD_DG,
	output logic [15:0]      CMD_DB,
	output logic [31:0]      CMD_DZ,
	output logic [10:0]      CMD_COUNT
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		CMD_VALID = 0; CMD_OP = 0; CMD_X = 0; CMD_Y = 0; CMD_COLOR = 0; CMD_Z = 0;
		CMD_DX = 16'h1000; CMD_DY = 0; CMD_DR = 0; CMD_DG = 0; CMD_DB = 0; CMD_DZ = 0; CMD_COUNT = 0;
	end
	// offer one primitive, hold it until taken or for at most 200 cycles
	task automatic send(input logic [1:0] op, input logic [10:0] x, input logic [9:0] y,
		input logic [23:0] col, input logic [23:0] z, input logic [10:0] cnt, output bit ok);
		int i;
		ok = 0;
		@(posedge clk);
		CMD_VALID <= 1'b1;
		CMD_OP    <= op;
		CMD_X     <= x;
		CMD_Y     <= y;
		CMD_COLOR <= col;
		CMD_Z     <= z;
		CMD_COUNT <= cnt;
		for (i = 0; i < 200 && !ok; i++) begin
			@(posedge clk);
			ok = CMD_READY;
		end
		CMD_VALID <= 1'b0;
		CMD_X     <= ~x;
		CMD_Z     <= ~z;
	endtask : send
endmodule : geom_src

// ---- sim/testbench.sv ----
// self-checking bench for the raster pixel writer
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import rast_pkg::*;
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin n_mismatch++; \
	$display("[FAIL] %s expected %h seen %h", n, e, s); end end
	typedef struct {logic [17:0] a; logic [2:0] l; logic [55:0] m; logic [55:0] d;} exp_t;
	logic CLK_SYS = 0, RESET = 1, REG_WR = 0, REG_RD = 0, CMD_VALID, CMD_READY, FB_RD, FB_WR, FB_QUAD, rd_pend = 0;
	logic [7:0] REG_ADDR = 0;
	logic [31:0] REG_WDATA = 0, REG_RDATA, seed = 32'habe41f16, ctrl = 0, modes = 0;
	logic [1:0] CMD_OP;
	logic [10:0] CMD_X, CMD_COUNT;
	logic [9:0] CMD_Y;
	logic [23:0] CMD_COLOR, CMD_Z, clr;
	logic [15:0] CMD_DX, CMD_DY, CMD_DR, CMD_DG, CMD_DB, drawn = 0, hid = 0;
	logic [31:0] CMD_DZ;
	logic [17:0] FB_ADDR;
	logic [2:0] FB_LANE;
	logic [55:0] FB_RDATA = 0, FB_WDATA, FB_WMASK, preset = 0;
	logic [55:0] mem [int];
	exp_t q[$];
	logic [31:0] rd_q[$];
	int n_mismatch = 0, num_checks = 0, i, n_clear = 0;
	bit ok;
	logic [31:0] rexp;
	always #25 CLK_SYS = ~CLK_SYS;
	raster_writer #(.HAS_EXT(1)) dut (.CLK_SYS(CLK_SYS), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
		.CMD_OP(CMD_OP), .CMD_X(CMD_X), .CMD_Y(CMD_Y), .CMD_COLOR(CMD_COLOR), .CMD_Z(CMD_Z), .CMD_DX(CMD_DX),
		.CMD_DY(CMD_DY), .CMD_DR(CMD_DR), .CMD_DG(CMD_DG), .CMD_DB(CMD_DB), .CMD_DZ(CMD_DZ), .CMD_COUNT(CMD_COUNT),
		.FB_ADDR(FB_ADDR), .FB_LANE(FB_LANE), .FB_RD(FB_RD), .FB_RDATA(FB_RDATA), .FB_WR(FB_WR),
		.FB_WDATA(FB_WDATA), .FB_WMASK(FB_WMASK), .FB_QUAD(FB_QUAD));
	geom_src g (.clk(CLK_SYS), .CMD_READY(CMD_READY), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_X(CMD_X),
		.CMD_Y(CMD_Y), .CMD_COLOR(CMD_COLOR), .CMD_Z(CMD_Z), .CMD_DX(CMD_DX), .CMD_DY(CMD_DY), .CMD_DR(CMD_DR),
		.CMD_DG(CMD_DG), .CMD_DB(CMD_DB), .CMD_DZ(CMD_DZ), .CMD_COUNT(CMD_COUNT));
	////////////////////////////////////////////////////////////////////////////////
	// frame buffer memory and result monitor
	always @(posedge CLK_SYS) begin
		if (FB_WR && !FB_QUAD)
			mem[{FB_ADDR, FB_LANE}] = ((mem.exists({FB_ADDR, FB_LANE}) ? mem[{FB_ADDR, FB_LANE}] : preset)
				& ~FB_WMASK) | (FB_WDATA & FB_WMASK);
		FB_RDATA <= FB_RD ? (mem.exists({FB_ADDR, FB_LANE}) ? mem[{FB_ADDR, FB_LANE}] : preset) : ~FB_RDATA;
		if (rd_pend) begin
			rexp = rd_q.pop_front();
			`CHK("reg read", rexp, REG_RDATA)
		end
		rd_pend <= REG_RD;
		if (FB_WR && FB_QUAD) begin
			`CHK("clear lane", 3'h7, FB_LANE)
			`CHK("clear data", {Z_FAR, 8'h00, clr}, FB_WDATA & 56'hffffff00ffffff)
			`CHK("clear addr", {n_clear[15:8], 2'b00, n_clear[7:0]}, FB_ADDR)
			`CHK("clear mask", 56'hffffff00ffffff, FB_WMASK)
			n_clear++;
		end else if (FB_WR && q.size() == 0)
			`CHK("stray write", 1'b0, FB_WR)
		else if (FB_WR) begin
			`CHK("address", q[0].a, FB_ADDR)
			`CHK("lane", q[0].l, FB_LANE)
			`CHK("mask", q[0].m, FB_WMASK)
			`CHK("data", q[0].d, FB_WDATA & FB_WMASK)
			void'(q.pop_front());
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// tasks
	task automatic stop_test();
		`CHK("pending writes", 0, q.size())
		if (n_mismatch == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_SYS);
		REG_WR <= 1; REG_ADDR <= a; REG_WDATA <= d;
		@(posedge CLK_SYS);
		REG_WR <= 0;
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		@(posedge CLK_SYS);
		REG_RD <= 1; REG_ADDR <= a;
		@(posedge CLK_SYS);
		REG_RD <= 0;
	endtask : reg_rd
	task automatic wait_idle(input int lim);
		int k;
		@(posedge CLK_SYS);
		for (k = 0; k < lim && !CMD_READY; k++)
			@(posedge CLK_SYS);
		if (!CMD_READY) begin
			n_mismatch++;
			stop_test();
		end
		@(negedge CLK_SYS);
	endtask : wait_idle
	// one primitive over a stored pixel of depth zo and window id w
	task automatic pix(input logic [1:0] op, input logic [10:0] x, input logic [9:0] y, input logic [23:0] c,
		input logic [23:0] z, input logic [23:0] zo, input logic [3:0] w, input logic [10:0] n);
		exp_t e;
		logic [1:0] md;
		int k;
		mem.delete();
		preset = {zo, 4'h0, w, c ^ 24'h5a5a5a};
		md = modes[2*w +: 2];
		e.m = {ctrl[CTL_DEPTH] ? 24'hffffff : 24'h0, 8'h00, md[MD_DBL] ? (ctrl[CTL_BACK] ? 24'hfff000 : 24'h000fff)
			: 24'hffffff};
		e.d = {z, 8'h00, md[MD_DBL] ? (ctrl[CTL_BACK] ? {c[11:0], 12'h0} : {12'h0, c[11:0]}) : c} & e.m;
		if (md == 2'b01 && ctrl[CTL_DITHER])
			for (k = 0; k < 24; k += 8)
				if (DITHER_TBL[{y[1:0], x[1:0], 2'b00} +: 4] < 4'h8 && c[k +: 8] != 8'hff)
					e.d[k +: 8] = c[k +: 8] + 8'h01;
		if (ctrl[CTL_WMASK] && w != 4'h0)
			n = n;
		else if (ctrl[CTL_DEPTH] && z >= zo)
			hid = hid + 16'(n + 1);
		else
			for (k = 0; k <= n; k++) begin
				e.a = {y, 8'((x + k) / 5)};
				e.l = 3'((x + k) % 5);
				q.push_back(e);
				drawn++;
			end
		g.send(op, x, y, c, z, n, ok);
		if (!ok) begin
			n_mismatch++;
			stop_test();
		end
		wait_idle(200);
	endtask : pix
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (4) @(posedge CLK_SYS);
		RESET <= 0;
		reg_rd(OFF_CTRL, 32'h0);
		reg_rd(OFF_STATUS, 32'h2);
		reg_wr(OFF_STATUS, 32'hffffffff);
		reg_rd(OFF_STATUS, 32'h2);
		reg_rd(8'h1c, 32'h0);
		modes = 32'h48;
		reg_wr(OFF_MODES, modes);
		for (i = 0; i < 12; i++) begin
			ctrl = {28'h0, 3'b000, 1'($random(seed))};
			reg_wr(OFF_CTRL, ctrl);
			pix(OP_SPAN, 11'($unsigned($random(seed)) % 1280), 10'($random(seed)), 24'($random(seed)),
				24'($random(seed)), 24'($random(seed)), 4'h0, 0);
		end
		ctrl = 32'h1;
		reg_wr(OFF_CTRL, ctrl);
		pix(OP_SPAN, 11'd7, 10'd3, 24'h123456, 24'h000400, 24'h000400, 4'h0, 0);
		pix(OP_SPAN, 11'd8, 10'd3, 24'h123456, 24'h000401, 24'h000400, 4'h0, 0);
		pix(OP_LINE, 11'd4, 10'd9, 24'habcdef, 24'h000010, 24'hfffff0, 4'h0, 1);
		pix(OP_SPAN, 11'd1279, 10'd1023, 24'h0f0f0f, 24'h000001, 24'h800000, 4'h0, 0);
		ctrl = 32'h9;
		reg_wr(OFF_CTRL, ctrl);
		pix(OP_SPAN, 11'd20, 10'd5, 24'h000abc, 24'h000020, 24'h000400, 4'h1, 0);
		reg_rd(OFF_HIDDEN, {16'h0, hid});
		reg_rd(OFF_DRAWN, {16'h0, drawn});
		ctrl = 32'h2;
		reg_wr(OFF_CTRL, ctrl);
		pix(OP_SPAN, 11'd12, 10'd4, 24'h40ff7f, 24'h000000, 24'h000000, 4'h3, 0);
		ctrl = 32'h5;
		reg_wr(OFF_CTRL, ctrl);
		reg_wr(OFF_TWID, 32'h0);
		pix(OP_SPAN, 11'd30, 10'd6, 24'h111111, 24'h000001, 24'h000400, 4'h2, 0);
		clr = 24'($random(seed));
		reg_wr(OFF_CLRCOL, {8'h0, clr});
		g.send(OP_CLEAR, 11'd0, 10'd0, 24'h0, 24'h0, 11'd0, ok);
		wait_idle(70000);
		`CHK("clear words", 65536, n_clear)
		repeat (2) @(posedge CLK_SYS);
		stop_test();
	end
endmodule : testbench
